//--- verilog/sfc_front_end.sv
// serial flash command front end: framing, registers, protection, boot
`include "sfc_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module sfc_front_end (
  input wire logic sys_clk_i,
  input wire logic rst_b_i,
  input wire logic sck_i,
  input wire logic cs_b_i,
  input wire logic wp_b_i,
  input wire logic [3:0] io_i,
  input wire logic [7:0] array_data_i,
  input wire logic array_busy_i,
  input wire logic prog_fail_i,
  input wire logic erase_fail_i,
  output sfc_pkg::sfc_lane_t lane_o,
  output sfc_pkg::sfc_req_t req_o,
  output logic [23:0] rd_addr_o
);
  import sfc_pkg::*;

  // ----------------------------------------------------------------
  // link synchronisers and edge finding
  // ----------------------------------------------------------------
  logic sck_m_q, sck_s_q, sck_p_q, cs_m_q, cs_s_q, cs_p_q, wp_m_q, wp_s_q;
  logic [3:0] io_m_q, io_s_q;
  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      {sck_m_q, sck_s_q, sck_p_q} <= 3'h0;
      {cs_m_q, cs_s_q, cs_p_q} <= 3'h7;
      {wp_m_q, wp_s_q} <= 2'h3;
      io_m_q <= 4'h0;
      io_s_q <= 4'h0;
    end else begin
      {sck_m_q, sck_s_q, sck_p_q} <= {sck_i, sck_m_q, sck_s_q};
      {cs_m_q, cs_s_q, cs_p_q} <= {cs_b_i, cs_m_q, cs_s_q};
      {wp_m_q, wp_s_q} <= {wp_b_i, wp_m_q};
      io_m_q <= io_i;
      io_s_q <= io_m_q;
    end
  end
  wire sck_rise = sck_s_q & ~sck_p_q;
  wire sck_fall = ~sck_s_q & sck_p_q;
  wire cs_fall = ~cs_s_q & cs_p_q;
  wire cs_rise = cs_s_q & ~cs_p_q;

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  sfc_state_t st_q, st_d;
  logic [7:0] op_q, op_d, osh_q, osh_d, fr_q, fr_d;
  logic [31:0] sh_q, sh_d, ab_q, ab_d;
  logic [5:0] cnt_q, cnt_d;
  logic [2:0] lanes_q, lanes_d, err_q, err_d;
  logic [23:0] addr_q, addr_d;
  logic [3:0] ocnt_q, ocnt_d, dmy_q, dmy_d;
  logic [7:2] sr_q, sr_d;
  logic ddr_q, ddr_d, wlat_q, wlat_d, fourl_q, fourl_d, rsten_q, rsten_d;
  logic boot_done_q, boot_done_d;
  sfc_lane_t out_q, out_d;
  sfc_req_t req_q, req_d;

  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rst_b_i);

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] shin(input logic [31:0] s, input logic [3:0] d,
                                       input logic [2:0] n);
    unique case (n)
      3'h1: shin = {s[30:0], d[0]};
      3'h2: shin = {s[29:0], d[1:0]};
      default: shin = {s[27:0], d};
    endcase
  endfunction : shin

  function automatic logic [7:0] shout(input logic [7:0] b, input logic [2:0] n);
    unique case (n)
      3'h1: shout = {b[6:0], 1'b0};
      3'h2: shout = {b[5:0], 2'h0};
      default: shout = {b[3:0], 4'h0};
    endcase
  endfunction : shout

  // single lane answers on the second pin, wider reads start at lane zero
  function automatic sfc_lane_t place(input logic [7:0] b, input logic [2:0] n);
    unique case (n)
      3'h1: place = '{dat: {2'h0, b[7], 1'b0}, oe: 4'h2};
      3'h2: place = '{dat: {2'h0, b[7:6]}, oe: 4'h3};
      default: place = '{dat: b[7:4], oe: 4'hF};
    endcase
  endfunction : place

  function automatic logic rd_arr(input logic [7:0] o);
    rd_arr = o == `SFC_OP_FAST_RD || o == `SFC_OP_QIO || o == `SFC_OP_DIO ||
             o == `SFC_OP_DDTR || o == `SFC_OP_QDTR;
  endfunction : rd_arr

  function automatic logic addr_wr(input logic [7:0] o);
    addr_wr = o == `SFC_OP_PP || o == `SFC_OP_SER || o == `SFC_OP_SERQ ||
              o == `SFC_OP_B32 || o == `SFC_OP_B64;
  endfunction : addr_wr

  function automatic logic [2:0] rd_lanes(input logic [7:0] o, input logic q);
    if (q || o == `SFC_OP_QIO || o == `SFC_OP_QDTR) rd_lanes = 3'h4;
    else if (o == `SFC_OP_DIO || o == `SFC_OP_DDTR) rd_lanes = 3'h2;
    else rd_lanes = 3'h1;
  endfunction : rd_lanes

  function automatic sfc_state_t next_st(input logic [7:0] o);
    if (rd_arr(o) || addr_wr(o)) next_st = ST_ADDR;
    else if (o == `SFC_OP_SR_WRITE || o == `SFC_OP_WRFR || o == `SFC_OP_WRAB) next_st = ST_DIN;
    else if (o == `SFC_OP_RDSR || o == `SFC_OP_RDER || o == `SFC_OP_RDAB ||
             o == `SFC_OP_RDFR) next_st = ST_DOUT;
    else if (o == `SFC_OP_WLATCH_SET || o == `SFC_OP_WRDI || o == `SFC_OP_CLER ||
             o == `SFC_OP_CER || o == `SFC_OP_CERQ || o == `SFC_OP_QPIEN ||
             o == `SFC_OP_QPIDI || o == `SFC_OP_RSTEN || o == `SFC_OP_RST) next_st = ST_WAIT;
    else next_st = ST_IGNORE;
  endfunction : next_st

  // 64 KB blocks; protect field n of 1 to 8 covers 2^(n-1) blocks from one end, 0 covers none, 9 and up all 128
  function automatic logic prot_hit(input logic [23:0] a, input logic [3:0] bp,
                                    input logic bottom);
    logic [7:0] n;
    logic [7:0] b;
    n = (bp >= 4'h8) ? 8'h80 : (bp == 4'h0) ? 8'h00 : 8'(8'h01 << (bp - 4'h1));
    b = {1'b0, a[22:16]};
    prot_hit = bottom ? (b < n) : (b >= 8'h80 - n);
  endfunction : prot_hit

  // ----------------------------------------------------------------
  // decode
  // ----------------------------------------------------------------
  wire shifting = st_q == ST_OP || st_q == ST_ADDR || st_q == ST_DIN;
  wire samp = shifting && !cs_s_q && (sck_rise || (ddr_q && sck_fall));
  wire drv = sck_fall || (ddr_q && sck_rise);
  wire [31:0] sh_n = shin(sh_q, io_s_q, lanes_q);
  wire [5:0] cnt_n = cnt_q + {3'h0, lanes_q};
  wire [7:0] opc = sh_n[7:0];
  wire quad = sr_q[`SFC_SR_QUAD];
  wire op_ddr = opc == `SFC_OP_DDTR || opc == `SFC_OP_QDTR;
  wire [2:0] op_lanes = rd_arr(opc) ? rd_lanes(opc, fourl_q) : lanes_q;
  wire [3:0] op_dmy = (opc == `SFC_OP_QIO || opc == `SFC_OP_QDTR) ? `SFC_QIO_DUMMY
                      : `SFC_FAST_DUMMY;
  wire boot_go = ab_q[`SFC_AB_EN] && !boot_done_q;
  wire [3:0] boot_dmy = (ab_q[4:1] != 4'h0) ? ab_q[4:1]
                        : quad ? `SFC_QIO_DUMMY : `SFC_FAST_DUMMY;
  wire is_pp = op_q == `SFC_OP_PP;
  wire [5:0] din_need = (op_q == `SFC_OP_WRAB) ? 6'h20 : 6'h08;
  wire din_take = is_pp || cnt_q < din_need;
  wire adr_done = st_q == ST_ADDR && samp && cnt_n == 6'h18 && !cs_rise;
  wire hit = prot_hit(sh_n[23:0], sr_q[5:2], fr_q[`SFC_FR_BOTTOM]);
  wire prot_err = adr_done && addr_wr(op_q) && wlat_q && hit;
  // other than page program, whose bytes go out as they complete, the operation only launches when select rises after a complete frame
  wire ex = cs_rise && (st_q == ST_WAIT ||
            (st_q == ST_DIN && (is_pp || cnt_q == din_need)));
  wire ex_w = ex && wlat_q;
  wire sr_lock = sr_q[`SFC_SR_SWD] && !wp_s_q;
  wire ex_srw = ex_w && op_q == `SFC_OP_SR_WRITE;
  wire ex_rst = ex && op_q == `SFC_OP_RST && rsten_q;
  wire is_cer = op_q == `SFC_OP_CER || op_q == `SFC_OP_CERQ;
  // chip erase with any block protected is dropped, and raises no flag
  wire ex_erase = ex_w && st_q == ST_WAIT &&
                  (addr_wr(op_q) || (is_cer && sr_q[5:2] == 4'h0));
  wire wr_class = addr_wr(op_q) || is_cer || op_q == `SFC_OP_SR_WRITE ||
                  op_q == `SFC_OP_WRFR || op_q == `SFC_OP_WRAB;
  sfc_kind_t er_kind;
  assign er_kind = is_cer ? K_CHIP : (op_q == `SFC_OP_B32) ? K_B32
                   : (op_q == `SFC_OP_B64) ? K_B64 : K_SECT;
  wire [7:0] sr_rd = {sr_q, wlat_q, array_busy_i};
  wire [7:0] er_rd = {`SFC_ER_FIXED, err_q, array_busy_i};
  wire [7:0] ab_byte = 8'(ab_q >> {~addr_q[1:0], 3'h0});
  wire [7:0] src_byte = (op_q == `SFC_OP_RDSR) ? sr_rd : (op_q == `SFC_OP_RDER) ? er_rd
                        : (op_q == `SFC_OP_RDFR) ? fr_q : (op_q == `SFC_OP_RDAB) ? ab_byte
                        : array_data_i;
  wire [7:0] obyte = (ocnt_q == 4'h0) ? src_byte : osh_q;

  // ----------------------------------------------------------------
  // frame sequencer
  // ----------------------------------------------------------------
  always_comb begin
    st_d = st_q;
    op_d = op_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    lanes_d = lanes_q;
    ddr_d = ddr_q;
    addr_d = addr_q;
    osh_d = osh_q;
    ocnt_d = ocnt_q;
    out_d = out_q;
    dmy_d = dmy_q;
    req_d = '0;
    if (cs_rise) begin
      st_d = ST_IDLE;
      out_d = '0;
      if (ex_erase) begin
        req_d.valid = 1'b1;
        req_d.kind = er_kind;
        req_d.addr = addr_q;
      end
    end else if (cs_fall) begin
      cnt_d = '0;
      sh_d = '0;
      ddr_d = 1'b0;
      ocnt_d = '0;
      lanes_d = fourl_q ? 3'h4 : 3'h1;
      st_d = ST_OP;
      if (boot_go) begin
        // boot read needs no opcode: straight into the delay count
        st_d = ST_DUMMY;
        op_d = quad ? `SFC_OP_QIO : `SFC_OP_FAST_RD;
        addr_d = {ab_q[23:5], 5'h00};
        dmy_d = boot_dmy;
      end
    end else begin
      unique case (st_q)
        ST_IDLE, ST_WAIT, ST_IGNORE: ;
        ST_OP: if (samp) begin
          sh_d = sh_n;
          cnt_d = cnt_n;
          if (cnt_n == 6'h08) begin
            op_d = opc;
            cnt_d = '0;
            st_d = next_st(opc);
            lanes_d = op_lanes;
            ddr_d = op_ddr;
            dmy_d = op_dmy;
            addr_d = '0;
          end
        end
        ST_ADDR: if (samp) begin
          sh_d = sh_n;
          cnt_d = cnt_n;
          if (cnt_n == 6'h18) begin
            addr_d = sh_n[23:0];
            cnt_d = '0;
            if (rd_arr(op_q)) st_d = ST_DUMMY;
            else if (!wlat_q || hit) st_d = ST_IGNORE;
            else st_d = is_pp ? ST_DIN : ST_WAIT;
          end
        end
        ST_DUMMY: if (sck_rise) begin
          // mode byte clocks are simply part of this count
          cnt_d = cnt_q + 6'h01;
          if (cnt_q + 6'h01 == {2'h0, dmy_q}) begin
            st_d = ST_DOUT;
            lanes_d = rd_lanes(op_q, fourl_q);
          end
        end
        ST_DIN: if (samp && din_take) begin
          sh_d = sh_n;
          cnt_d = cnt_n;
          if (is_pp && cnt_n == 6'h08) begin
            cnt_d = '0;
            req_d = '{valid: 1'b1, kind: K_PROG, addr: addr_q, data: sh_n[7:0]};
            addr_d = {addr_q[23:8], addr_q[7:0] + 8'h01};
          end
        end
        ST_DOUT: if (drv) begin
          osh_d = shout(obyte, lanes_q);
          out_d = place(obyte, lanes_q);
          ocnt_d = ((ocnt_q == 4'h0) ? 4'h8 : ocnt_q) - {1'b0, lanes_q};
          if (ocnt_q == 4'h0) addr_d = addr_q + 24'h000001;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------
  // registers and flags
  // ----------------------------------------------------------------
  wire [2:0] err_set;
  wire err_clr = ex_rst || (ex && op_q == `SFC_OP_CLER);
  assign err_set[`SFC_ERR_PROT] = (ex_srw && sr_lock) || prot_err;
  assign err_set[`SFC_ERR_PERR] = (prot_err && is_pp) || prog_fail_i;
  assign err_set[`SFC_ERR_EERR] = (ex_srw && sr_lock) || (prot_err && !is_pp) ||
                                  erase_fail_i;
  // a flag raised in the clearing cycle survives; flags never gate decode
  assign err_d = (err_q & ~{3{err_clr}}) | err_set;
  assign sr_d = (ex_srw && !sr_lock) ? sh_q[7:2] : sr_q;
  assign fr_d = (ex_w && op_q == `SFC_OP_WRFR) ? (fr_q | (sh_q[7:0] & `SFC_FR_WR_MASK))
                : fr_q;
  assign ab_d = (ex_w && op_q == `SFC_OP_WRAB) ? (sh_q & `SFC_AB_WR_MASK) : ab_q;
  assign wlat_d = (ex_rst || (ex && op_q == `SFC_OP_WRDI) || (ex_w && wr_class)) ? 1'b0
                  : (ex && op_q == `SFC_OP_WLATCH_SET) ? 1'b1 : wlat_q;
  assign fourl_d = (ex_rst || (ex && op_q == `SFC_OP_QPIDI)) ? 1'b0
                   : (ex && op_q == `SFC_OP_QPIEN) ? 1'b1 : fourl_q;
  assign rsten_d = ex ? (op_q == `SFC_OP_RSTEN) : rsten_q;
  // software reset re-arms boot, else a boot setting could never take effect
  assign boot_done_d = !ex_rst && (boot_done_q || cs_fall);

  always_ff @(posedge sys_clk_i) begin
    if (!rst_b_i) begin
      st_q <= ST_IDLE;
      {op_q, osh_q, sh_q, cnt_q, addr_q, ocnt_q, dmy_q} <= '0;
      {lanes_q, ddr_q, out_q, req_q} <= '0;
      {wlat_q, fourl_q, rsten_q, boot_done_q, err_q} <= '0;
      sr_q <= `SFC_SR_RST;
      fr_q <= `SFC_FR_RST;
      ab_q <= `SFC_AB_RST;
    end else begin
      {st_q, op_q, osh_q, sh_q, cnt_q, addr_q} <= {st_d, op_d, osh_d, sh_d, cnt_d, addr_d};
      {ocnt_q, dmy_q, lanes_q, ddr_q, out_q, req_q} <=
        {ocnt_d, dmy_d, lanes_d, ddr_d, out_d, req_d};
      {wlat_q, fourl_q, rsten_q, boot_done_q, err_q} <=
        {wlat_d, fourl_d, rsten_d, boot_done_d, err_d};
      {sr_q, fr_q, ab_q} <= {sr_d, fr_d, ab_d};
    end
  end
  assign lane_o = out_q;
  assign req_o = req_q;
  assign rd_addr_o = addr_q;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  a_otp_only_rise: assert property ((fr_q & $past(fr_q)) == $past(fr_q))
    else $error("one-time bit returned to zero");
  a_sr_write_bits: assert property (ex_srw && !sr_lock |=> sr_q == $past(sh_q[7:2]))
    else $error("status write took wrong bits");
  a_err_sticky: assert property (!err_clr |=> (err_q & $past(err_q)) == $past(err_q))
    else $error("error flag dropped without clear");
  a_err_cleared: assert property (err_clr && err_set == 3'h0 |=> err_q == 3'h0)
    else $error("error flags not cleared");
  a_err_no_block: assert property (ex && op_q == `SFC_OP_WLATCH_SET && err_q != 3'h0 |=> wlat_q)
    else $error("write enable refused while errors set");
  a_ab_reserved: assert property (ab_q[31:24] == 8'h00)
    else $error("reserved boot bits nonzero");
  a_sr_locked: assert property (ex_srw && sr_lock |=> $stable(sr_q) &&
    err_q[`SFC_ERR_PROT] && err_q[`SFC_ERR_EERR]) else $error("locked status write");
  a_latch_gate: assert property (req_q.valid |-> $past(wlat_q))
    else $error("array request without write enable");
  a_prot_stop: assert property (prot_err |=> st_q == ST_IGNORE ##1 !req_q.valid)
    else $error("protected address not stopped");
  a_boot_entry: assert property (cs_fall && boot_go |=> st_q == ST_DUMMY &&
    addr_q == {ab_q[23:5], 5'h00}) else $error("boot read not started");
  a_boot_delay: assert property (cs_fall && boot_go && ab_q[4:1] == 4'h0 |=>
    dmy_q == (quad ? 4'h6 : 4'h8)) else $error("default boot delay wrong");
  a_dummy_end: assert property (st_q == ST_DUMMY && sck_rise && !cs_rise &&
    cnt_q + 6'h01 == {2'h0, dmy_q} |=> st_q == ST_DOUT) else $error("dummy count wrong");
  a_msb_first: assert property (st_q == ST_DOUT && drv && ocnt_q == 4'h0 &&
    lanes_q == 3'h1 && !cs_rise |=> out_q.dat[1] == $past(src_byte[7]))
    else $error("first output bit not msb");
  a_ignore_quiet: assert property (st_q == ST_IGNORE && !cs_rise |=>
    $stable(sr_q) && $stable(fr_q) && $stable(ab_q) && !req_q.valid)
    else $error("ignored opcode changed state");
  c_boot_read: cover property (cs_fall && boot_go ##[1:1000] st_q == ST_DOUT);
  c_locked_srw: cover property (ex_srw && sr_lock);
  c_quad_ddr: cover property (st_q == ST_DOUT && ddr_q && lanes_q == 3'h4 && drv);
  c_clear: cover property (err_q != 3'h0 ##1 err_clr);
endmodule : sfc_front_end
`default_nettype wire

//--- verilog/sfc_consts.svh
// constants of the serial flash command front end
`ifndef SFC_CONSTS_SVH
`define SFC_CONSTS_SVH
`define SFC_OP_WLATCH_SET 8'h06
`define SFC_OP_WRDI 8'h04
`define SFC_OP_RDSR 8'h05
`define SFC_OP_SR_WRITE 8'h01
`define SFC_OP_RDER 8'h81
`define SFC_OP_CLER 8'h82
`define SFC_OP_RDAB 8'h14
`define SFC_OP_WRAB 8'h15
`define SFC_OP_RDFR 8'h48
`define SFC_OP_WRFR 8'h42
`define SFC_OP_PP 8'h02
`define SFC_OP_SER 8'hD7
`define SFC_OP_SERQ 8'h20
`define SFC_OP_B32 8'h52
`define SFC_OP_B64 8'hD8
`define SFC_OP_CER 8'hC7
`define SFC_OP_CERQ 8'h60
`define SFC_OP_FAST_RD 8'h0B
`define SFC_OP_QIO 8'hEB
`define SFC_OP_DIO 8'hBB
`define SFC_OP_DDTR 8'hBD
`define SFC_OP_QDTR 8'hED
`define SFC_OP_QPIEN 8'h35
`define SFC_OP_QPIDI 8'hF5
`define SFC_OP_RSTEN 8'h66
`define SFC_OP_RST 8'h99
`define SFC_SR_SWD 7
`define SFC_SR_QUAD 6
`define SFC_SR_RST 6'h00
`define SFC_ER_FIXED 4'hF
`define SFC_ERR_PROT 0
`define SFC_ERR_PERR 1
`define SFC_ERR_EERR 2
`define SFC_FR_BOTTOM 1
`define SFC_FR_WR_MASK 8'hFE
`define SFC_FR_RST 8'h00
`define SFC_AB_WR_MASK 32'h00FFFFFF
`define SFC_AB_RST 32'h00000000
`define SFC_AB_EN 0
`define SFC_FAST_DUMMY 4'h8
`define SFC_QIO_DUMMY 4'h6
`endif

//--- verilog/sfc_pkg.sv
// types of the serial flash command front end
package sfc_pkg;
  typedef enum logic [2:0] {
    ST_IDLE, ST_OP, ST_ADDR, ST_DUMMY, ST_DIN, ST_DOUT, ST_WAIT, ST_IGNORE
  } sfc_state_t;
  typedef enum logic [2:0] {K_PROG, K_SECT, K_B32, K_B64, K_CHIP} sfc_kind_t;
  typedef struct packed {
    logic [3:0] dat;
    logic [3:0] oe;
  } sfc_lane_t;
  typedef struct packed {
    logic valid;
    sfc_kind_t kind;
    logic [23:0] addr;
    logic [7:0] data;
  } sfc_req_t;
endpackage : sfc_pkg

//--- test/sfc_host_model.sv
// host flash controller model for the serial link
`timescale 1ns/1ps
`default_nettype none
module sfc_host_model (
  input wire logic sys_clk_i,
  input wire logic [3:0] dat_i,
  output logic sck_o,
  output logic cs_b_o,
  output logic [3:0] io_o
);
  initial begin
    sck_o = 1'b0;
    cs_b_o = 1'b1;
    io_o = 4'hA;
  end
  // half a link period is four system clocks; sck stands low between frames
  task automatic half();
    repeat (4) @(posedge sys_clk_i);
    #2;
  endtask : half
  task automatic open_frame();
    cs_b_o = 1'b0;
    half();
  endtask : open_frame
  // io only moves while sck is low, so it is stable across the latching rise
  task automatic send(input logic [31:0] val, input int nbits, input int lanes);
    for (int i = nbits - lanes; i >= 0; i -= lanes) begin
      sck_o = 1'b0;
      case (lanes)
        1: io_o = {~io_o[3:1], val[i]};
        2: io_o = {~io_o[3:2], val[i+:2]};
        default: io_o = val[i+:4];
      endcase
      half();
      sck_o = 1'b1;
      half();
    end
  endtask : send
  // sample late in the high phase; released lanes keep toggling meanwhile
  task automatic recv(output logic [31:0] val, input int nbits, input int lanes);
    val = 32'h0;
    for (int i = 0; i < nbits; i += lanes) begin
      sck_o = 1'b0;
      io_o = ~io_o;
      half();
      sck_o = 1'b1;
      half();
      case (lanes)
        1: val = {val[30:0], dat_i[1]};
        2: val = {val[29:0], dat_i[1:0]};
        default: val = {val[27:0], dat_i};
      endcase
    end
  endtask : recv
  task automatic close_frame();
    sck_o = 1'b0;
    half();
    cs_b_o = 1'b1;
    io_o = ~io_o;
    repeat (3) half();
  endtask : close_frame
endmodule : sfc_host_model
`default_nettype wire

//--- test/tb_sfc_front_end.sv
// self-checking bench of the serial flash command front end
`timescale 1ns/1ps
`default_nettype none
`include "sfc_consts.svh"
module tb_sfc_front_end;
  import sfc_pkg::*;
  logic sys_clk_i;
  logic rst_b_i;
  logic wp_b_i;
  logic busy;
  logic prog_fail;
  logic erase_fail;
  wire logic sck;
  wire logic cs_b;
  wire logic [3:0] io;
  sfc_lane_t lane;
  sfc_req_t req;
  logic [23:0] rd_addr;
  wire logic [7:0] array_data;
  sfc_req_t reqs[$];
  int miscompares = 0;
  int tests_run = 0;
  // array model: each byte is its low address bits scrambled
  assign array_data = rd_addr[7:0] ^ 8'h5A;
  sfc_front_end DUT (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i), .sck_i(sck), .cs_b_i(cs_b),
    .wp_b_i(wp_b_i), .io_i(io), .array_data_i(array_data), .array_busy_i(busy),
    .prog_fail_i(prog_fail), .erase_fail_i(erase_fail), .lane_o(lane), .req_o(req),
    .rd_addr_o(rd_addr));
  sfc_host_model HOST (.sys_clk_i(sys_clk_i), .dat_i(lane.dat), .sck_o(sck), .cs_b_o(cs_b),
    .io_o(io));
  initial begin
    sys_clk_i = 1'b0;
    forever #10 sys_clk_i = ~sys_clk_i;
  end
  always @(posedge sys_clk_i) begin
    if (rst_b_i === 1'b1 && req.valid === 1'b1) begin
      reqs.push_back(req);
    end
  end
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_i);
    #2;
  endtask : tick
  task automatic hw_reset();
    rst_b_i = 1'b0;
    tick(20);
    rst_b_i = 1'b1;
    tick(4);
  endtask : hw_reset
  task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
    tests_run++;
    if (got !== exp) begin
      miscompares++;
      $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask : check
  task automatic check_req(input sfc_kind_t k, input logic [23:0] a, input logic [7:0] d);
    sfc_req_t r;
    r = '0;
    tests_run++;
    if (reqs.size() != 0) r = reqs.pop_front();
    if (r.valid !== 1'b1 || r.kind !== k || r.addr !== a || r.data !== d) begin
      miscompares++;
      $display("[FAIL] %0t request %h expected %0d %h %h", $time, r, k, a, d);
    end
  endtask : check_req
  task automatic cmd(input logic [7:0] op, input logic [31:0] arg, input int nbits);
    HOST.open_frame();
    HOST.send({24'h0, op}, 8, 1);
    HOST.send(arg, nbits, 1);
    HOST.close_frame();
  endtask : cmd
  task automatic rd(input logic [7:0] op, input int n, input logic [31:0] exp, input string s);
    logic [31:0] v;
    HOST.open_frame();
    HOST.send({24'h0, op}, 8, 1);
    HOST.recv(v, n, 1);
    HOST.close_frame();
    check(v, exp, s);
  endtask : rd
  task automatic t_reset_state();
    check({lane, rd_addr}, 32'h0, "outputs at reset");
    check({28'h0, req.valid, req.kind}, 32'h0, "request at reset");
    rd(`SFC_OP_RDSR, 8, 32'h00, "status at reset");
    rd(`SFC_OP_RDAB, 32, 32'h0, "boot reg at reset");
    rd(`SFC_OP_RDFR, 8, 32'h00, "function reg at reset");
    busy = 1'b1;
    rd(`SFC_OP_RDER, 8, 32'hF1, "extended with busy");
    busy = 1'b0;
  endtask : t_reset_state
  task automatic t_latch_and_requests();
    cmd(`SFC_OP_SERQ, 32'h012345, 24);
    check(reqs.size(), 0, "erase without latch");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    rd(`SFC_OP_RDSR, 8, 32'h02, "latch set");
    cmd(`SFC_OP_SERQ, 32'h012345, 24);
    check_req(K_SECT, 24'h012345, 8'h00);
    rd(`SFC_OP_RDSR, 8, 32'h00, "latch after erase");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_B64, 32'h020000, 24);
    check_req(K_B64, 24'h020000, 8'h00);
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_CER, 0, 0);
    check_req(K_CHIP, 24'h000000, 8'h00);
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_WRDI, 0, 0);
    rd(`SFC_OP_RDSR, 8, 32'h00, "latch after disable");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    HOST.open_frame();
    HOST.send({24'h0, `SFC_OP_PP}, 8, 1);
    HOST.send(32'h0000FF, 24, 1);
    HOST.send(32'h1122, 16, 1);
    HOST.close_frame();
    check_req(K_PROG, 24'h0000FF, 8'h11);
    check_req(K_PROG, 24'h000000, 8'h22);
  endtask : t_latch_and_requests
  task automatic t_error_flags();
    erase_fail = 1'b1;
    tick(1);
    erase_fail = 1'b0;
    rd(`SFC_OP_RDER, 8, 32'hF8, "erase error set");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    rd(`SFC_OP_RDSR, 8, 32'h02, "command with error set");
    rd(`SFC_OP_RDER, 8, 32'hF8, "erase error sticky");
    cmd(`SFC_OP_CLER, 0, 0);
    rd(`SFC_OP_RDER, 8, 32'hF0, "cleared by command");
    prog_fail = 1'b1;
    tick(1);
    prog_fail = 1'b0;
    rd(`SFC_OP_RDER, 8, 32'hF4, "program error set");
    cmd(`SFC_OP_RSTEN, 0, 0);
    cmd(`SFC_OP_RST, 0, 0);
    rd(`SFC_OP_RDER, 8, 32'hF0, "cleared by soft reset");
    erase_fail = 1'b1;
    tick(1);
    erase_fail = 1'b0;
    hw_reset();
    rd(`SFC_OP_RDER, 8, 32'hF0, "cleared by hard reset");
  endtask : t_error_flags
  task automatic t_protection();
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_SR_WRITE, 32'h80, 8);
    rd(`SFC_OP_RDSR, 8, 32'h80, "disable bit set");
    wp_b_i = 1'b0;
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_SR_WRITE, 32'h7C, 8);
    rd(`SFC_OP_RDSR, 8, 32'h80, "locked status");
    rd(`SFC_OP_RDER, 8, 32'hFA, "locked write errors");
    wp_b_i = 1'b1;
    cmd(`SFC_OP_CLER, 0, 0);
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_SR_WRITE, 32'h23, 8);
    rd(`SFC_OP_RDSR, 8, 32'h20, "status with pin high");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_SERQ, 32'h400000, 24);
    check(reqs.size(), 0, "erase of protected area");
    rd(`SFC_OP_RDER, 8, 32'hFA, "protection error");
    cmd(`SFC_OP_CLER, 0, 0);
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_SR_WRITE, 32'h00, 8);
    rd(`SFC_OP_RDSR, 8, 32'h00, "protection removed");
  endtask : t_protection
  task automatic t_reads();
    logic [31:0] v;
    HOST.open_frame();
    HOST.send({24'h0, `SFC_OP_FAST_RD}, 8, 1);
    HOST.send(32'h0001FE, 24, 1);
    HOST.send(32'h0, 8, 1);
    HOST.recv(v, 16, 1);
    HOST.close_frame();
    check(v, 32'hA4A5, "fast read");
    HOST.open_frame();
    HOST.send({24'h0, `SFC_OP_QIO}, 8, 1);
    HOST.send(32'h000310, 24, 4);
    HOST.send(32'hA00000, 24, 4);
    HOST.recv(v, 16, 4);
    HOST.close_frame();
    check(v, 32'h4A4B, "quad read");
  endtask : t_reads
  task automatic t_registers();
    HOST.open_frame();
    HOST.send(32'hA5, 8, 1);
    HOST.send(32'h06060606, 32, 1);
    HOST.close_frame();
    rd(`SFC_OP_RDSR, 8, 32'h00, "unknown opcode");
    check(reqs.size(), 0, "no stray request");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_WRAB, 32'hFFFFFFFF, 32);
    rd(`SFC_OP_RDAB, 32, 32'h00FFFFFF, "boot reg");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_WRFR, 32'hFF, 8);
    rd(`SFC_OP_RDFR, 8, 32'hFE, "function reg set");
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_WRFR, 32'h00, 8);
    rd(`SFC_OP_RDFR, 8, 32'hFE, "one-time bits kept");
  endtask : t_registers
  // boot from 0x120 with the default delay of eight rising edges
  task automatic t_boot();
    logic [31:0] v;
    cmd(`SFC_OP_WLATCH_SET, 0, 0);
    cmd(`SFC_OP_WRAB, 32'h00000121, 32);
    cmd(`SFC_OP_RSTEN, 0, 0);
    cmd(`SFC_OP_RST, 0, 0);
    HOST.open_frame();
    HOST.send(32'h0, 8, 1);
    HOST.recv(v, 16, 1);
    HOST.close_frame();
    check(v, 32'h7A7B, "boot read");
  endtask : t_boot
  task automatic conclude();
    $display("comparisons %0d mismatches %0d", tests_run, miscompares);
    if (miscompares == 0 && tests_run > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : conclude
  initial begin
    #1500000;
    miscompares++;
    $display("[FAIL] %0t run did not finish", $time);
    conclude();
  end
  initial begin
    rst_b_i = 1'b0;
    wp_b_i = 1'b1;
    busy = 1'b0;
    prog_fail = 1'b0;
    erase_fail = 1'b0;
    hw_reset();
    t_reset_state();
    t_latch_and_requests();
    t_error_flags();
    t_protection();
    t_reads();
    t_registers();
    t_boot();
    conclude();
  end
endmodule : tb_sfc_front_end
`default_nettype wire
